// ==== include/eeprom_link_if.sv ====
`timescale 1ns/1ps
interface eeprom_link_if;
   logic scl;
   logic wp;
   logic m_sda_o;
   logic m_sda_oe;
   logic t_sda_o;
   logic t_sda_oe;
   logic sda_line;

   // open-drain wired-and with pull-up
   assign sda_line = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));

   modport target (input scl, input wp, input sda_line,
                   output t_sda_o, output t_sda_oe);
   modport host (output scl, output wp, output m_sda_o, output m_sda_oe,
                 input sda_line);
endinterface

// ==== include/eeprom_pkg.sv ====
package eeprom_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int WRITE_TIME_MS = 10;
   // longest programming time, rounded down to whole cycles
   localparam int WRITE_CYC = WRITE_TIME_MS * (CLK_HZ / 1000);
   localparam int SCL_HZ = 100_000;
   localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
   localparam int ADDR_W = 9;
   localparam int MEM_BYTES = 1 << ADDR_W;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_IDX_W = 4;
   // device type code: value is arbitrary
   localparam logic [3:0] TYPE_CODE = 4'h6;
   localparam int DEV_TYPE_LSB = 4;
   localparam int DEV_HALF_BIT = 1;
   localparam int DEV_RW_BIT = 0;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] ACK_DONE = 4'h9;

   typedef enum logic [2:0]
   {
      T_IDLE = 3'b000,
      T_DEV = 3'b001,
      T_WORD = 3'b010,
      T_DATA = 3'b011,
      T_READ = 3'b100,
      T_WAIT = 3'b101,
      T_BUSY = 3'b110
   } tgt_state_t;

   typedef enum logic [1:0]
   {
      M_IDLE = 2'b00,
      M_START = 2'b01,
      M_BIT = 2'b10,
      M_STOP = 2'b11
   } host_state_t;
endpackage

// ==== rtl/eeprom_host.sv ====
`timescale 1ns/1ps
module eeprom_host
   import eeprom_pkg::*;
#(
   parameter int QUARTER = QUARTER_CYC,
   parameter int FIFO_DEPTH = 2,
   parameter int FIFO_W = 8
)
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   eeprom_link_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_start_i,
   input wire logic cmd_stop_i,
   input wire logic cmd_read_i,
   input wire logic cmd_ack_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic wp_i,
   output logic ack_seen_o,
   output logic done_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [FIFO_W-1:0] rd_data_o
);
   localparam int DIV_W = $clog2(QUARTER + 1);
   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      next_ptr = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   host_state_t state_reg;
   logic [DIV_W-1:0] div_reg;
   logic [1:0] q_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic rd_reg, mack_reg, stop_reg;
   logic scl_reg, sda_low_reg, wp_reg, ack_reg, done_reg;
   logic sda_s1, sda_s2;
   logic [FIFO_W-1:0] fifo_mem [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [CW-1:0] count_reg;

   wire fifo_full = count_reg == CW'(FIFO_DEPTH);
   wire accept = cmd_valid_i && cmd_ready_o;
   wire tick = (state_reg != M_IDLE) && (div_reg == DIV_W'(QUARTER - 1));
   wire ack_slot = bit_reg == ACK_BIT;
   // ack slot: read drives ack only if asked, a final read leaves it high
   wire bit_low = ack_slot ? (rd_reg && mack_reg) :
                  (!rd_reg && !sh_reg[7]);
   wire early_low = (state_reg == M_STOP) ||
                    ((state_reg == M_BIT) && bit_low);
   wire late_low = (state_reg == M_START) ||
                   ((state_reg == M_BIT) && bit_low);
   wire bit_end = tick && (q_reg == 2'h3) && (state_reg == M_BIT);
   wire push = bit_end && ack_slot && rd_reg;
   wire pop = rd_valid_o && rd_ready_i;

   // stalls read commands while the buffer cannot take the byte
   assign cmd_ready_o = (state_reg == M_IDLE) && !(cmd_read_i && fifo_full);

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         {sda_s1, sda_s2} <= 2'h3;
         div_reg <= '0;
      end
      else
      begin
         {sda_s1, sda_s2} <= {link.sda_line, sda_s1};
         div_reg <= (accept || tick) ? '0 : div_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         fifo_mem[wr_ptr_reg] <= sh_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= next_ptr(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= next_ptr(rd_ptr_reg);
         end
         count_reg <= count_reg + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= M_IDLE;
         q_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         {rd_reg, mack_reg, stop_reg} <= 3'h0;
         scl_reg <= 1'b1;
         sda_low_reg <= 1'b0;
         wp_reg <= 1'b0;
         ack_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         // user holds wp steady until programming is seen done
         wp_reg <= wp_i;
         done_reg <= 1'b0;
         if (accept)
         begin
            state_reg <= cmd_start_i ? M_START : M_BIT;
            sh_reg <= cmd_data_i;
            {rd_reg, mack_reg, stop_reg} <=
               {cmd_read_i, cmd_ack_i, cmd_stop_i};
            bit_reg <= 4'h0;
            q_reg <= 2'h0;
            scl_reg <= 1'b0;
         end
         else if (tick)
         begin
            q_reg <= q_reg + 1'b1;
            case (q_reg)
               2'h0: sda_low_reg <= early_low;
               2'h1: scl_reg <= 1'b1;
               2'h2: sda_low_reg <= late_low;
               default:
               begin
                  scl_reg <= 1'b0;
                  if (state_reg == M_START)
                  begin
                     state_reg <= M_BIT;
                  end
                  else if (state_reg == M_STOP)
                  begin
                     state_reg <= M_IDLE;
                     scl_reg <= 1'b1;
                     done_reg <= 1'b1;
                  end
                  else if (!ack_slot)
                  begin
                     sh_reg <= {sh_reg[6:0], sda_s2};
                     bit_reg <= bit_reg + 1'b1;
                  end
                  else
                  begin
                     if (!rd_reg)
                     begin
                        ack_reg <= !sda_s2;
                     end
                     state_reg <= stop_reg ? M_STOP : M_IDLE;
                     done_reg <= !stop_reg;
                  end
               end
            endcase
         end
      end
   end

   assign link.scl = scl_reg;
   assign link.wp = wp_reg;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = sda_low_reg;
   assign ack_seen_o = ack_reg;
   assign done_o = done_reg;
   assign rd_valid_o = count_reg != '0;
   assign rd_data_o = fifo_mem[rd_ptr_reg];
endmodule

// ==== rtl/eeprom_target.sv ====
`timescale 1ns/1ps
module eeprom_target
   import eeprom_pkg::*;
#(
   parameter int WRITE_CYCLES = WRITE_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   eeprom_link_if.target link,
   output logic busy_o,
   output logic [ADDR_W-1:0] cur_addr_o
);
   localparam int CYC_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [PAGE_IDX_W:0] PAGE_END = (PAGE_IDX_W + 1)'(PAGE_BYTES);

   tgt_state_t state_reg;
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic rw_reg;
   logic mack_reg;
   logic drv_low_reg;
   logic [PAGE_BYTES-1:0] valid_reg;
   logic [PAGE_IDX_W:0] prog_idx_reg;
   logic [CYC_W-1:0] busy_cnt_reg;
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;
   logic wp_s1, wp_s2;
   logic [7:0] page_buf [PAGE_BYTES];
   logic [7:0] mem [MEM_BYTES];

   wire scl_rise = scl_s2 && !scl_d;
   wire scl_fall = !scl_s2 && scl_d;
   wire start_det = scl_s2 && scl_d && sda_d && !sda_s2;
   wire stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
   wire recv_st = (state_reg == T_DEV) || (state_reg == T_WORD) ||
                  (state_reg == T_DATA);
   wire active_st = recv_st || (state_reg == T_READ);
   wire dev_match = sh_reg[7:DEV_TYPE_LSB] == TYPE_CODE;
   wire byte_end = scl_fall && (cnt_reg == ACK_BIT);
   wire buf_we = byte_end && (state_reg == T_DATA);
   wire [PAGE_IDX_W-1:0] page_idx = addr_reg[PAGE_IDX_W-1:0];
   wire [PAGE_IDX_W-1:0] page_idx_inc = page_idx + 1'b1;
   wire [ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
   wire [7:0] rd_byte = mem[addr_reg];
   wire [PAGE_IDX_W-1:0] prog_idx = prog_idx_reg[PAGE_IDX_W-1:0];
   wire [ADDR_W-1:0] prog_addr = {addr_reg[ADDR_W-1:PAGE_IDX_W], prog_idx};
   wire prog_run = (state_reg == T_BUSY) && (prog_idx_reg != PAGE_END);
   // wp is rechecked per byte; a change mid-cycle writes only the bytes whose slot came while it was low
   wire prog_en = prog_run && valid_reg[prog_idx] && !wp_s2;
   wire write_go = (state_reg == T_DATA) && (|valid_reg) && !wp_s2;
   wire busy_last = busy_cnt_reg == CYC_W'(WRITE_CYCLES - 1);

   // pins come from outside this clock, so two flops each
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         {scl_s1, scl_s2, scl_d} <= 3'h7;
         {sda_s1, sda_s2, sda_d} <= 3'h7;
         {wp_s1, wp_s2} <= 2'h3;
      end
      else
      begin
         {scl_s1, scl_s2, scl_d} <= {link.scl, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_d} <= {link.sda_line, sda_s1, sda_s2};
         {wp_s1, wp_s2} <= {link.wp, wp_s1};
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (buf_we)
      begin
         page_buf[page_idx] <= sh_reg;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (prog_en)
      begin
         mem[prog_addr] <= page_buf[prog_idx];
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= T_IDLE;
         cnt_reg <= 4'h0;
         sh_reg <= 8'h00;
         addr_reg <= '0;
         rw_reg <= 1'b0;
         mack_reg <= 1'b0;
         drv_low_reg <= 1'b0;
         valid_reg <= '0;
         prog_idx_reg <= '0;
         busy_cnt_reg <= '0;
      end
      else if (state_reg == T_BUSY)
      begin
         // bus is ignored entirely while programming
         drv_low_reg <= 1'b0;
         busy_cnt_reg <= busy_cnt_reg + 1'b1;
         if (prog_run)
         begin
            prog_idx_reg <= prog_idx_reg + 1'b1;
         end
         if (busy_last)
         begin
            state_reg <= T_IDLE;
            valid_reg <= '0;
         end
      end
      else if (start_det)
      begin
         state_reg <= T_DEV;
         cnt_reg <= 4'h0;
         drv_low_reg <= 1'b0;
      end
      else if (stop_det)
      begin
         cnt_reg <= 4'h0;
         drv_low_reg <= 1'b0;
         if (write_go)
         begin
            state_reg <= T_BUSY;
            busy_cnt_reg <= '0;
            prog_idx_reg <= '0;
         end
         else
         begin
            state_reg <= T_IDLE;
            valid_reg <= '0;
         end
      end
      else if (scl_rise && active_st && (cnt_reg != ACK_DONE))
      begin
         cnt_reg <= cnt_reg + 1'b1;
         if (recv_st && (cnt_reg < ACK_BIT))
         begin
            sh_reg <= {sh_reg[6:0], sda_s2};
         end
         if ((state_reg == T_READ) && (cnt_reg == ACK_BIT))
         begin
            mack_reg <= !sda_s2;
         end
      end
      else if (scl_fall && active_st)
      begin
         if (byte_end && recv_st)
         begin
            drv_low_reg <= 1'b1;
            case (state_reg)
               T_DEV:
               begin
                  if (dev_match)
                  begin
                     rw_reg <= sh_reg[DEV_RW_BIT];
                     addr_reg[ADDR_W-1] <= sh_reg[DEV_HALF_BIT];
                     if (!sh_reg[DEV_RW_BIT])
                     begin
                        valid_reg <= '0;
                     end
                  end
                  else
                  begin
                     drv_low_reg <= 1'b0;
                     state_reg <= T_WAIT;
                  end
               end
               T_WORD:
               begin
                  addr_reg[ADDR_W-2:0] <= sh_reg;
               end
               T_DATA:
               begin
                  // bytes past the page end wrap onto earlier ones
                  valid_reg[page_idx] <= 1'b1;
                  addr_reg[PAGE_IDX_W-1:0] <= page_idx_inc;
               end
               default:
               begin
                  drv_low_reg <= 1'b0;
               end
            endcase
         end
         else if (cnt_reg == ACK_DONE)
         begin
            cnt_reg <= 4'h0;
            drv_low_reg <= 1'b0;
            case (state_reg)
               T_DEV:
               begin
                  if (rw_reg)
                  begin
                     state_reg <= T_READ;
                     sh_reg <= {rd_byte[6:0], 1'b0};
                     drv_low_reg <= !rd_byte[7];
                  end
                  else
                  begin
                     state_reg <= T_WORD;
                  end
               end
               T_WORD:
               begin
                  state_reg <= T_DATA;
               end
               T_READ:
               begin
                  if (mack_reg)
                  begin
                     sh_reg <= {rd_byte[6:0], 1'b0};
                     drv_low_reg <= !rd_byte[7];
                  end
                  else
                  begin
                     state_reg <= T_WAIT;
                  end
               end
               default:
               begin
                  state_reg <= state_reg;
               end
            endcase
         end
         else if (state_reg == T_READ)
         begin
            if (cnt_reg < ACK_BIT)
            begin
               sh_reg <= {sh_reg[6:0], 1'b0};
               drv_low_reg <= !sh_reg[7];
            end
            else
            begin
               drv_low_reg <= 1'b0;
            end
            if (cnt_reg == LAST_DATA_BIT)
            begin
               addr_reg <= addr_inc;
            end
         end
      end
   end

   assign link.t_sda_o = 1'b0;
   assign link.t_sda_oe = drv_low_reg;
   assign busy_o = state_reg == T_BUSY;
   assign cur_addr_o = addr_reg;
endmodule

// ==== sim/eeprom_link_asserts.sv ====
`timescale 1ns/1ps
module eeprom_link_asserts
#(
   parameter int WRITE_CYCLES = 1000
)
(
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic scl,
   input wire logic sda_line,
   input wire logic t_sda_oe,
   input wire logic busy_o
);
   logic [31:0] busy_cnt_reg;
   logic [3:0] fall_cnt_reg;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // counts the programming cycle so its length is checked exactly
   always_ff @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         busy_cnt_reg <= '0;
      else
         busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h1 : '0;

   // cycles since the last clock fall, saturating so it never wraps
   always_ff @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         fall_cnt_reg <= 4'hf;
      else if ($fell(scl))
         fall_cnt_reg <= 4'h0;
      else if (fall_cnt_reg != 4'hf)
         fall_cnt_reg <= fall_cnt_reg + 4'h1;

   sequence s_busy_rise;
      $rose(busy_o);
   endsequence

   sequence s_quiet;
      !t_sda_oe [*8];
   endsequence

   no_busy_ack_a: assert property (busy_o |-> !t_sda_oe)
      else $error("target drives data line while programming");
   busy_quiet_a: assert property (s_busy_rise |-> s_quiet)
      else $error("target answers right after programming starts");
   busy_length_a: assert property (
      $fell(busy_o) |-> busy_cnt_reg == WRITE_CYCLES)
      else $error("programming cycle has the wrong length");
   stop_busy_a: assert property (
      $rose(busy_o) |-> scl && sda_line)
      else $error("programming started without a stop");
   ack_stable_a: assert property (
      scl && $past(scl) |-> $stable(t_sda_oe))
      else $error("target changes data line while clock is high");
   drive_low_scl_a: assert property ($rose(t_sda_oe) |-> !scl)
      else $error("target pulls data line while clock is high");
   release_low_a: assert property ($fell(t_sda_oe) |-> !scl)
      else $error("target releases data line while clock is high");
   drive_latency_a: assert property (
      $rose(t_sda_oe) |-> fall_cnt_reg < 4'hc)
      else $error("target drive too late after clock fall");
endmodule

// ==== sim/test_serial_eeprom_rw_engine.sv ====
`timescale 1ns/1ps
module test_serial_eeprom_rw_engine;
   import eeprom_pkg::*;
   localparam int WC = 1000;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i;
   logic [7:0] cmd_data_i;
   logic wp_i, rd_ready_i;
   logic cmd_ready_o, ack_seen_o, done_o, rd_valid_o, busy_o;
   logic [7:0] rd_data_o;
   logic [ADDR_W-1:0] cur_addr_o;
   int mem [MEM_BYTES];
   int rdq [$];
   int exp_addr;
   int seed = 14;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;

   eeprom_link_if lnk ();

   eeprom_target #(.WRITE_CYCLES(WC)) i_eeprom_target (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(lnk),
      .busy_o(busy_o), .cur_addr_o(cur_addr_o));

   eeprom_host #(.QUARTER(10)) i_eeprom_host (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(lnk),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .cmd_start_i(cmd_start_i), .cmd_stop_i(cmd_stop_i),
      .cmd_read_i(cmd_read_i), .cmd_ack_i(cmd_ack_i),
      .cmd_data_i(cmd_data_i), .wp_i(wp_i), .ack_seen_o(ack_seen_o),
      .done_o(done_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
      .rd_data_o(rd_data_o));

   eeprom_link_asserts #(.WRITE_CYCLES(WC)) i_eeprom_link_asserts (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .scl(lnk.scl),
      .sda_line(lnk.sda_line), .t_sda_oe(lnk.t_sda_oe), .busy_o(busy_o));

   always #12.5 ref_clk_i = ~ref_clk_i;

   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ignored bits set to 10 so a design that compares them is caught
   function automatic logic [7:0] dev(input logic h, input logic r);
      return {TYPE_CODE, 2'b10, h, r};
   endfunction

   task automatic cmd(input logic s, p, r, k, input logic [7:0] d);
      @(posedge ref_clk_i);
      #1;
      {cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i, cmd_data_i} =
         {s, p, r, k, d};
      cmd_valid_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      cmd_valid_i = 1'b0;
      while (done_o !== 1'b1)
      begin
         @(posedge ref_clk_i);
         #1;
      end
   endtask

   task automatic pop;
      while (rd_valid_o !== 1'b1)
      begin
         @(posedge ref_clk_i);
         #1;
      end
      check(rd_data_o, rdq.pop_front());
      rd_ready_i = 1'b1;
      @(posedge ref_clk_i);
      #1;
      rd_ready_i = 1'b0;
   endtask

   task automatic wr_page(input logic [8:0] a, input int n, input logic p);
      logic [7:0] d;
      int k;
      wp_i = p;
      cmd(1, 0, 0, 0, dev(a[8], 0));
      check(ack_seen_o, 1);
      cmd(0, 0, 0, 0, a[7:0]);
      check(ack_seen_o, 1);
      for (int i = 0; i < n; i++)
      begin
         d = 8'($random(seed));
         k = {a[8:4], a[3:0] + i[3:0]};
         if (!p)
            mem[k] = d;
         cmd(0, i == n - 1, 0, 0, d);
         check(ack_seen_o, 1);
      end
      exp_addr = {a[8:4], a[3:0] + n[3:0]};
      check(cur_addr_o, exp_addr);
      check(busy_o, !p);
      check(lnk.sda_line, 1);
      k = 0;
      // polls with write direction so a stop can always follow the ack
      do
      begin
         cmd(1, 1, 0, 0, dev(a[8], 0));
         k++;
      end
      while (ack_seen_o !== 1'b1 && k < 8);
      check(k > 1, !p);
      check(busy_o, 0);
   endtask

   task automatic rd_bytes(input logic [8:0] a, input int n, input logic rnd);
      if (rnd)
      begin
         cmd(1, 0, 0, 0, dev(a[8], 0));
         cmd(0, 0, 0, 0, a[7:0]);
         exp_addr = a;
      end
      cmd(1, 0, 0, 0, dev(exp_addr[8], 1));
      check(ack_seen_o, 1);
      // the receiver stalls one byte behind to keep the buffer full
      for (int i = 0; i < n; i++)
      begin
         rdq.push_back(mem[exp_addr]);
         exp_addr = (exp_addr + 1) % MEM_BYTES;
         cmd(0, i == n - 1, 1, i < n - 1, 8'h00);
         if (i > 0)
         begin
            @(posedge ref_clk_i);
            #1;
            check(cmd_ready_o, 0);
            pop();
         end
      end
      pop();
      check(cur_addr_o, exp_addr);
   endtask

   initial
   begin
      logic [31:0] r;
      {cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_ack_i} = '0;
      cmd_data_i = 8'h00;
      rd_ready_i = 1'b0;
      wp_i = 1'b0;
      repeat (20) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      check(cur_addr_o, 0);
      wr_page(9'h1fa, 18, 1'b0);
      wr_page(9'h000, 1, 1'b0);
      // protected bytes land where the reads below look
      wr_page(9'h1fe, 3, 1'b1);
      rd_bytes(9'h1fe, 3, 1'b1);
      rd_bytes(9'h1f0, 1, 1'b1);
      // foreign type code: no ack, and the address stays put
      cmd(1, 1, 0, 0, {~TYPE_CODE, 4'h0});
      check(ack_seen_o, 0);
      check(cur_addr_o, exp_addr);
      rd_bytes(9'h000, 2, 1'b0);
      r = $random(seed);
      // keeps both bytes inside one page so the read finds them
      r[3] = 1'b0;
      wr_page(r[8:0], 2, 1'b0);
      rd_bytes(r[8:0], 2, 1'b1);
      close_out();
   end
endmodule
